// ---- rtl/ptic_pkg.sv ----
// Constants shared by the paired timer and input capture block
package ptic_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam logic [7:0] OFS_LO_CTL = 8'h00;
  localparam logic [7:0] OFS_HI_CTL = 8'h04;
  localparam logic [7:0] OFS_CAP_CTL = 8'h08;
  localparam logic [7:0] OFS_CAP_BUF = 8'h0C;
  localparam logic [7:0] OFS_LO_CNT = 8'h10;
  localparam logic [7:0] OFS_HI_CNT = 8'h14;
  localparam logic [7:0] OFS_LO_PER = 8'h18;
  localparam logic [7:0] OFS_HI_PER = 8'h1C;
  // Timer control field positions
  localparam int BIT_RUN = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_GATE = 6;
  localparam int BIT_PS_HI = 5;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_PAIR = 3;
  localparam int BIT_CLK_SRC = 1;
  // Capture control field positions
  localparam int BIT_CAP_TSEL = 7;
  localparam int BIT_CAP_ICI_HI = 6;
  localparam int BIT_CAP_ICI_LO = 5;
  localparam int BIT_CAP_OVF = 4;
  localparam int BIT_CAP_BNE = 3;
  // Writable bits of each control register
  localparam logic [15:0] LO_CTL_MASK = 16'hA07A;
  localparam logic [15:0] HI_CTL_MASK = 16'hA072;
  localparam logic [15:0] CAP_CTL_MASK = 16'h20E7;
  // Values after reset
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] PER_RESET = 16'hFFFF;
  // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] PS_TC_1 = 8'h00;
  localparam logic [7:0] PS_TC_8 = 8'h07;
  localparam logic [7:0] PS_TC_64 = 8'h3F;
  localparam logic [7:0] PS_TC_256 = 8'hFF;
  // Capture mode codes
  localparam logic [2:0] CM_OFF = 3'h0;
  localparam logic [2:0] CM_EVERY = 3'h1;
  localparam logic [2:0] CM_FALL = 3'h2;
  localparam logic [2:0] CM_RISE = 3'h3;
  localparam logic [2:0] CM_RISE4 = 3'h4;
  localparam logic [2:0] CM_RISE16 = 3'h5;
  localparam logic [2:0] CM_WAKE = 3'h7;
  // Edge counts per capture in the prescaled modes, minus one
  localparam logic [3:0] EDGE_TC_4 = 4'h3;
  localparam logic [3:0] EDGE_TC_16 = 4'hF;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- rtl/ptic_top.sv ----
// Paired 16/32-bit timers with one input capture channel, AXI4-Lite registers
// Operation
// - Low run bit starts whole pair timer
// - Pair bit joins both timers into 32
// - Idle-stop bit halts timer in Idle
// - Gating works only with internal clock
// - Prescale divides by 1, 8, 64, 256
// - Low timer counts external pin rising edges
// - High timer counts own pin or internal
// - High controls ignored in pair mode, except idle-stop
// - Capture latches 16-bit selected timer value
// - Select bit 1 low timer, 0 high
// - Interrupt after every 1 to 4 captures
// - Four-word FIFO read in arrival order
// - Overflow flag read-only, cleared by hardware
// - Not-empty flag shows unread buffered values
// - Mode field selects edge kind and prescale
// - Mode 111 is sleep/idle wake input only
// - Modes 000 and 110 disable channel
// - Every-edge mode ignores interrupt count field
// - Capture idle-stop halts channel in Idle, except mode 111 wake
// - Capture pin event wakes the device
// - Low word least, high word most significant
// - Pair match signalled through high timer flag
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
module ptic_top
  import ptic_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic low_timer_ext_clock_pin,
  input wire logic high_timer_ext_clock_pin,
  input wire logic low_timer_gate_pin,
  input wire logic high_timer_gate_pin,
  input wire logic capture_input_pin,
  input wire logic idle_mode,
  input wire logic sleep_mode,
  output logic low_timer_match_q,
  output logic high_timer_match_q,
  output logic capture_int_q,
  output logic wake_q
);

  // Elaboration check: pointers and fill counter are sized for four words
  if (FIFO_DEPTH != 4) begin
    $error("ptic_top: FIFO_DEPTH must be 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Prescaler terminal count for a 2-bit select code
  function automatic logic [7:0] ps_tc(input logic [1:0] sel);
    unique case (sel)
      2'b00: ps_tc = PS_TC_1;
      2'b01: ps_tc = PS_TC_8;
      2'b10: ps_tc = PS_TC_64;
      2'b11: ps_tc = PS_TC_256;
    endcase
  endfunction

  // Byte-lane merge of a 16-bit register with write data
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree

  logic [4:0] pins;
  logic [4:0] sync1_q, sync2_q, sync3_q; // Only sync2_q reads sync1_q
  logic [4:0] filt_q; // Debounced pin levels
  logic [4:0] filt_prev_q; // Levels one cycle ago, for edges
  logic [4:0] rise, fall;
  assign pins = {capture_input_pin, high_timer_gate_pin, low_timer_gate_pin,
                 high_timer_ext_clock_pin, low_timer_ext_clock_pin};
  assign rise = filt_q & ~filt_prev_q;
  assign fall = ~filt_q & filt_prev_q;

  // Synchroniser chain and agreement filter
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q <= '0;
      filt_prev_q <= '0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));
      filt_prev_q <= filt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0] lo_ctl_q, hi_ctl_q, cap_ctl_q; // Writable control bits only
  logic [15:0] lo_cnt_q, hi_cnt_q, lo_per_q, hi_per_q;
  logic aw_have_q, w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_go; // Write applied this cycle
  logic ar_take; // Read accepted this cycle
  logic pop; // Read of the capture buffer
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign pop = ar_take && (s_axi_araddr == OFS_CAP_BUF);

  // Decoded controls; pair mode lets the low register drive everything but the high idle-stop bit
  logic pair, lo_run, lo_ext, lo_gate, hi_run, hi_ext, hi_gate;
  logic [1:0] lo_ps, hi_ps;
  assign pair = lo_ctl_q[BIT_PAIR];
  assign lo_run = lo_ctl_q[BIT_RUN] && !(idle_mode && (lo_ctl_q[BIT_IDLE_STOP]
                  || (pair && hi_ctl_q[BIT_IDLE_STOP])));
  assign lo_ext = lo_ctl_q[BIT_CLK_SRC];
  assign lo_gate = lo_ctl_q[BIT_GATE] && !lo_ext;
  assign lo_ps = lo_ctl_q[BIT_PS_HI:BIT_PS_LO];
  assign hi_run = hi_ctl_q[BIT_RUN] && !pair
                  && !(idle_mode && hi_ctl_q[BIT_IDLE_STOP]);
  assign hi_ext = hi_ctl_q[BIT_CLK_SRC];
  assign hi_gate = hi_ctl_q[BIT_GATE] && !hi_ext;
  assign hi_ps = hi_ctl_q[BIT_PS_HI:BIT_PS_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Capture FIFO state, declared here for the read path

  logic [15:0] fifo_mem [0:3]; // Captured words
  logic [1:0] wr_ptr_q, rd_ptr_q;
  logic [2:0] fill_q; // Words held, 0 to 4
  logic ovf_q;
  logic bne;
  assign bne = (fill_q != 3'd0);

  // Read data mux
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      OFS_LO_CTL: rd_mux[15:0] = lo_ctl_q;
      OFS_HI_CTL: rd_mux[15:0] = hi_ctl_q;
      OFS_CAP_CTL: rd_mux[15:0] = cap_ctl_q | {11'h000, ovf_q, bne, 3'h0};
      OFS_CAP_BUF: rd_mux[15:0] = bne ? fifo_mem[rd_ptr_q] : 16'h0000;
      OFS_LO_CNT: rd_mux[15:0] = lo_cnt_q;
      OFS_HI_CNT: rd_mux[15:0] = hi_cnt_q;
      OFS_LO_PER: rd_mux[15:0] = lo_per_q;
      OFS_HI_PER: rd_mux[15:0] = hi_per_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // Write address and data channels, accepted in either order
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end else if (!aw_have_q && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end else if (!w_have_q && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response, one cycle after both halves are held
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_q <= OFS_HI_PER && aw_addr_q[1:0] == 2'b00
                      && aw_addr_q != OFS_CAP_BUF) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel; the buffer pops on the accepting edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Control and period registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lo_ctl_q <= CTL_RESET;
      hi_ctl_q <= CTL_RESET;
      cap_ctl_q <= CTL_RESET;
      lo_per_q <= PER_RESET;
      hi_per_q <= PER_RESET;
    end else if (wr_go) begin
      unique case (aw_addr_q)
        OFS_LO_CTL: lo_ctl_q <= merge16(lo_ctl_q, w_data_q, w_strb_q) & LO_CTL_MASK;
        OFS_HI_CTL: hi_ctl_q <= merge16(hi_ctl_q, w_data_q, w_strb_q) & HI_CTL_MASK;
        // Status bits are masked off: software cannot touch them
        OFS_CAP_CTL: cap_ctl_q <= merge16(cap_ctl_q, w_data_q, w_strb_q) & CAP_CTL_MASK;
        OFS_LO_PER: lo_per_q <= merge16(lo_per_q, w_data_q, w_strb_q);
        OFS_HI_PER: hi_per_q <= merge16(hi_per_q, w_data_q, w_strb_q);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer clocking: source, gate and prescaler

  logic [7:0] lo_pcnt_q, hi_pcnt_q;
  logic lo_src, hi_src, lo_tick, hi_tick;
  // External source counts debounced rising edges, internal counts every cycle
  assign lo_src = (lo_ext ? rise[0] : 1'b1) && (!lo_gate || filt_q[2]);
  assign hi_src = (hi_ext ? rise[1] : 1'b1) && (!hi_gate || filt_q[3]);
  assign lo_tick = lo_run && lo_src && (lo_pcnt_q >= ps_tc(lo_ps));
  assign hi_tick = hi_run && hi_src && (hi_pcnt_q >= ps_tc(hi_ps));

  // Prescalers; the compare is >= so a smaller ratio never strands the count
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lo_pcnt_q <= '0;
      hi_pcnt_q <= '0;
    end else begin
      if (lo_run && lo_src) lo_pcnt_q <= lo_tick ? 8'h00 : lo_pcnt_q + 8'h01;
      if (hi_run && hi_src) hi_pcnt_q <= hi_tick ? 8'h00 : hi_pcnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer counters and period match

  logic lo_hit, pair_hit, hi_hit;
  assign lo_hit = (lo_cnt_q == lo_per_q);
  assign pair_hit = lo_hit && (hi_cnt_q == hi_per_q);
  assign hi_hit = (hi_cnt_q == hi_per_q);

  // Counting; a software write wins over a tick in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lo_cnt_q <= '0;
      hi_cnt_q <= '0;
    end else begin
      if (wr_go && aw_addr_q == OFS_LO_CNT) begin
        lo_cnt_q <= merge16(lo_cnt_q, w_data_q, w_strb_q);
      end else if (lo_tick) begin
        lo_cnt_q <= (pair ? pair_hit : lo_hit) ? 16'h0000 : lo_cnt_q + 16'h0001;
      end
      if (wr_go && aw_addr_q == OFS_HI_CNT) begin
        hi_cnt_q <= merge16(hi_cnt_q, w_data_q, w_strb_q);
      end else if (pair) begin
        // High word advances on the low word's carry
        if (lo_tick && pair_hit) hi_cnt_q <= 16'h0000;
        else if (lo_tick && lo_cnt_q == 16'hFFFF) hi_cnt_q <= hi_cnt_q + 16'h0001;
      end else if (hi_tick) begin
        hi_cnt_q <= hi_hit ? 16'h0000 : hi_cnt_q + 16'h0001;
      end
    end
  end

  // Match pulses; in pair mode only the high flag fires
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      low_timer_match_q <= 1'b0;
      high_timer_match_q <= 1'b0;
    end else begin
      low_timer_match_q <= !pair && lo_tick && lo_hit;
      high_timer_match_q <= pair ? (lo_tick && pair_hit) : (hi_tick && hi_hit);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture event detection

  logic [2:0] cmode, cmode_prev_q;
  logic [1:0] ici;
  logic cap_halt, cap_rise, cap_fall, cap_ev, wake_ev, edge_tc;
  logic [3:0] edge_cnt_q; // Rising edges seen in prescaled modes
  logic [1:0] ev_cnt_q; // Captures since last interrupt
  assign cmode = cap_ctl_q[2:0];
  assign ici = cap_ctl_q[BIT_CAP_ICI_HI:BIT_CAP_ICI_LO];
  assign cap_halt = idle_mode && cap_ctl_q[BIT_IDLE_STOP];
  assign cap_rise = rise[4];
  assign cap_fall = fall[4];
  assign edge_tc = (edge_cnt_q == (cmode == CM_RISE4 ? EDGE_TC_4 : EDGE_TC_16));

  // Event qualification per mode; off and the unused code never capture
  always_comb begin
    cap_ev = 1'b0;
    if (!cap_halt && cmode == cmode_prev_q) begin
      unique case (cmode)
        CM_EVERY: cap_ev = cap_rise || cap_fall;
        CM_FALL: cap_ev = cap_fall;
        CM_RISE: cap_ev = cap_rise;
        CM_RISE4, CM_RISE16: cap_ev = cap_rise && edge_tc;
        default: cap_ev = 1'b0;
      endcase
    end
  end
  // Wake only ever counts rising edges in mode 111, in any other mode the capture
  assign wake_ev = (sleep_mode || idle_mode)
                   && ((cmode == CM_WAKE) ? cap_rise : cap_ev);

  // Edge prescaler; restarting on a mode change avoids a short first period
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      edge_cnt_q <= '0;
      cmode_prev_q <= CM_OFF;
    end else begin
      cmode_prev_q <= cmode;
      if (cmode != cmode_prev_q) edge_cnt_q <= 4'h0;
      else if (!cap_halt && cap_rise && (cmode == CM_RISE4 || cmode == CM_RISE16))
        edge_cnt_q <= edge_tc ? 4'h0 : edge_cnt_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture FIFO

  logic [15:0] cap_val;
  logic cap_full;
  assign cap_val = cap_ctl_q[BIT_CAP_TSEL] ? lo_cnt_q : hi_cnt_q;
  assign cap_full = (fill_q == 3'd4);

  // Storage; a capture into a full buffer is dropped
  always_ff @(posedge sys_clk) begin
    if (cap_ev && !cap_full) fifo_mem[wr_ptr_q] <= cap_val;
  end

  // Pointers and fill level; turning the channel off empties it
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cmode == CM_OFF) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q <= '0;
    end else begin
      if (cap_ev && !cap_full) wr_ptr_q <= wr_ptr_q + 2'd1;
      if (pop && bne) rd_ptr_q <= rd_ptr_q + 2'd1;
      fill_q <= fill_q + {2'b00, cap_ev && !cap_full} - {2'b00, pop && bne};
    end
  end

  // Overflow flag; only the hardware clears it, when the channel is turned off
  always_ff @(posedge sys_clk) begin
    if (sys_rst) ovf_q <= 1'b0;
    else if (cap_ev && cap_full) ovf_q <= 1'b1;
    else if (cmode == CM_OFF) ovf_q <= 1'b0;
  end

  // Interrupt decimation and wake pulse
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cmode != cmode_prev_q) begin
      ev_cnt_q <= '0;
      capture_int_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_ev;
      capture_int_q <= 1'b0;
      if (cap_ev) begin
        if (cmode == CM_EVERY || ev_cnt_q == ici) begin
          capture_int_q <= 1'b1;
          ev_cnt_q <= 2'd0;
        end else begin
          ev_cnt_q <= ev_cnt_q + 2'd1;
        end
      end else if (cmode == CM_WAKE && wake_ev) begin
        capture_int_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence write_pending_s;
    aw_have_q && w_have_q && !s_axi_bvalid;
  endsequence
  sequence full_capture_s;
    cap_ev && cap_full && cmode != CM_OFF;
  endsequence

  axi_write_resp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    write_pending_s |=> s_axi_bvalid && !aw_have_q && !w_have_q)
    else $error("write response not raised one cycle after both halves");
  fifo_overflow_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    full_capture_s ##0 !pop |=> ovf_q && fill_q == 3'd4 && $stable(wr_ptr_q))
    else $error("capture into full buffer altered the buffer or missed overflow");
  ovf_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ovf_q && cmode != CM_OFF && !(wr_go && aw_addr_q == OFS_CAP_CTL) |=> ovf_q)
    else $error("overflow flag cleared while channel active");
  fifo_fill_step_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cap_ev && !cap_full && !pop && cmode != CM_OFF |=> fill_q == $past(fill_q) + 3'd1)
    else $error("capture did not add one word to the buffer");
  lo_idle_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    idle_mode && lo_ctl_q[BIT_IDLE_STOP] && !wr_go |=> $stable(lo_cnt_q))
    else $error("low timer advanced in idle with idle-stop set");
  pair_carry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pair && lo_tick && lo_cnt_q == 16'hFFFF && !pair_hit && !wr_go
    |=> hi_cnt_q == $past(hi_cnt_q) + 16'h0001 && lo_cnt_q == 16'h0000)
    else $error("pair carry into high word failed");
  direct_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    lo_run && !lo_ext && !lo_gate && lo_ps == 2'b00 && !lo_hit && !pair && !wr_go
    |=> lo_cnt_q == $past(lo_cnt_q) + 16'h0001)
    else $error("low timer at 1:1 did not count every cycle");
  off_no_capture_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cmode == CM_OFF || cmode == 3'h6 || cmode == CM_WAKE) |-> !cap_ev)
    else $error("capture in a disabled or wake-only mode");
  wake_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cmode == CM_WAKE && cmode_prev_q == CM_WAKE && cap_rise && sleep_mode
    |=> wake_q && capture_int_q ##1 !wake_q)
    else $error("wake-only mode missed a rising edge");
  rise4_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cap_ev && cmode == CM_RISE4 |-> edge_cnt_q == EDGE_TC_4)
    else $error("every-4th mode captured on wrong edge");
  pair_match_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pair |=> !low_timer_match_q)
    else $error("low match flag fired in pair mode");

endmodule

// ---- sim/ptic_pin_model.sv ----
// Far-side pins: capture input pulse source and free-running external timer clocks
module ptic_pin_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [4:0] num,
  output logic capture_input_pin,
  output logic low_timer_ext_clock_pin,
  output logic high_timer_ext_clock_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] div_q = 8'h00; // Free divider for the external clocks
  logic [5:0] left_q = 6'h00; // Pin toggles still to make
  logic [2:0] ph_q = 3'h0; // Eight cycles per pin level, well above the filter
  logic pin_q = 1'b0; // Capture pin level, idle low
  assign capture_input_pin = pin_q;
  // External clocks run free, as a crystal-driven pin would
  assign low_timer_ext_clock_pin = div_q[2];
  assign high_timer_ext_clock_pin = div_q[3];
  ////////////////////////////////////////////////////////////////////////////
  // Pulse train: each pulse is one rising and one falling edge, 16 cycles long
  always @(posedge sys_clk) begin
    div_q <= div_q + 8'h01;
    ph_q <= ph_q + 3'h1;
    if (go && left_q == 6'h00) begin
      left_q <= {num, 1'b0};
      ph_q <= 3'h0;
    end else if (left_q != 6'h00 && ph_q == 3'h7) begin
      pin_q <= ~pin_q;
      left_q <= left_q - 6'h01;
    end
  end
endmodule

// ---- sim/ptic_tb_top.sv ----
// Self-checking bench for the paired timer and capture block
module ptic_tb_top;
  import ptic_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, sys_rst = 1'b1, go = 1'b0, idle_mode = 1'b0, sleep_mode = 1'b0;
  logic [4:0] num = 5'h00;
  logic gate = 1'b1; // Drives both timer gate pins
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cap_pin, lo_ck, hi_ck;
  logic lo_m, hi_m, cap_int, wake;
  logic [1:0] bresp, rresp, r;
  logic [15:0] v, prev;
  int num_errors = 0, cmp_count = 0, n_int = 0, n_wake = 0, n_lo = 0, n_hi = 0;
  always #2 sys_clk = ~sys_clk;
  ptic_pin_model pins_u (.sys_clk(sys_clk), .go(go), .num(num), .capture_input_pin(cap_pin),
    .low_timer_ext_clock_pin(lo_ck), .high_timer_ext_clock_pin(hi_ck));
  ptic_top #(.FIFO_DEPTH(4)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .low_timer_ext_clock_pin(lo_ck), .high_timer_ext_clock_pin(hi_ck),
    .low_timer_gate_pin(gate), .high_timer_gate_pin(gate), .capture_input_pin(cap_pin),
    .idle_mode(idle_mode), .sleep_mode(sleep_mode), .low_timer_match_q(lo_m),
    .high_timer_match_q(hi_m), .capture_int_q(cap_int), .wake_q(wake));
  // Event pulses stand one cycle; counted mid-cycle, clear of the tasks' resets
  always @(negedge sys_clk) begin
    if (cap_int === 1'b1) n_int++;
    if (wake === 1'b1) n_wake++;
    if (lo_m === 1'b1) n_lo++;
    if (hi_m === 1'b1) n_hi++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Readies are registers, so the level seen mid-cycle is the one the next edge samples
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic ta, tw, tb;
    awaddr <= a; wdata <= {16'h0000, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ta = awvalid & awready; tw = wvalid & wready; tb = bvalid; r = bresp;
      @(posedge sys_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ta = arvalid & arready; tr = rvalid; r = rresp; v = rdata[15:0];
      @(posedge sys_clk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Pulse train of fixed pacing, then let the filter and FIFO settle
  task automatic pulse(input logic [4:0] n);
    go <= 1'b1; num <= n;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (16 * n + 16) @(posedge sys_clk);
  endtask
  task automatic close_out;
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset values, masks and refused addresses
  task automatic t_regs;
    rd(OFS_LO_CTL); check({r, v}, {RESP_OKAY, CTL_RESET});
    rd(OFS_HI_PER); check({r, v}, {RESP_OKAY, PER_RESET});
    rd(8'h20); check({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(OFS_CAP_BUF, 16'h1234); check({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(OFS_LO_CTL, 16'hFFFF); rd(OFS_LO_CTL); check(v, LO_CTL_MASK);
    wr(OFS_CAP_CTL, 16'hFFFF); rd(OFS_CAP_CTL); check(v, CAP_CTL_MASK);
    wr(OFS_CAP_CTL, 16'h0000); wr(OFS_LO_CTL, 16'h0000);
  endtask
  // Four captures fill the FIFO, a fifth overflows, pops come in order 16 counts apart
  task automatic t_fifo;
    wr(OFS_LO_CTL, 16'h8000); wr(OFS_CAP_CTL, 16'h00E3); n_int = 0;
    pulse(5'd4); check(n_int, 1);
    rd(OFS_CAP_CTL); check(v, 16'h00EB);
    pulse(5'd1); rd(OFS_CAP_CTL); check(v, 16'h00FB);
    rd(OFS_CAP_BUF); prev = v;
    for (int i = 0; i < 3; i++) begin
      rd(OFS_CAP_BUF); check(16'(v - prev), 16'h0010);
      prev = v;
    end
    rd(OFS_CAP_BUF); check(v, 16'h0000);
    rd(OFS_CAP_CTL); check(v, 16'h00F3);
  endtask
  // Every-edge, falling and every-4th modes; off clears state; wake mode never captures
  task automatic t_wake;
    wr(OFS_CAP_CTL, 16'h0061);
    n_int = 0;
    pulse(5'd1);
    wr(OFS_CAP_CTL, 16'h0002);
    pulse(5'd1);
    wr(OFS_CAP_CTL, 16'h0004);
    pulse(5'd8);
    check(n_int, 5);
    wr(OFS_CAP_CTL, 16'h0000); rd(OFS_CAP_CTL); check(v, 16'h0000);
    wr(OFS_CAP_CTL, 16'h0007); sleep_mode <= 1'b1; n_int = 0; n_wake = 0;
    pulse(5'd1); check({n_int[15:0], n_wake[15:0]}, 32'h0001_0001);
    rd(OFS_CAP_CTL); check(v, 16'h0007);
    sleep_mode <= 1'b0;
  endtask
  // Count match pulses over 40 cycles, starting from zero
  task automatic win;
    n_lo = 0;
    n_hi = 0;
    repeat (40) @(posedge sys_clk);
  endtask
  // Match pulses: period 4 alone and paired, 1:8, external clock, gate held low
  task automatic t_timer;
    wr(OFS_LO_CTL, 16'h0000);
    wr(OFS_LO_CNT, 16'h0000);
    wr(OFS_LO_PER, 16'h0003);
    wr(OFS_LO_CTL, 16'h8000);
    win;
    check({n_lo[15:0], n_hi[15:0]}, 32'h000A_0000);
    wr(OFS_HI_PER, 16'h0000);
    wr(OFS_LO_CTL, 16'h8008);
    win;
    check({n_lo[15:0], n_hi[15:0]}, 32'h0000_000A);
    wr(OFS_LO_PER, 16'h0000);
    wr(OFS_LO_CNT, 16'h0000);
    wr(OFS_LO_CTL, 16'h8010);
    win;
    check({n_lo[15:0], n_hi[15:0]}, 32'h0005_0000);
    gate <= 1'b0;
    wr(OFS_LO_CTL, 16'h8042);
    win;
    check({n_lo[15:0], n_hi[15:0]}, 32'h0005_0000);
    wr(OFS_LO_CTL, 16'h8040);
    win;
    check({n_lo[15:0], n_hi[15:0]}, 32'h0000_0000);
  endtask
  // Idle stop halts the pair; with both idle-stop bits clear it keeps counting
  task automatic t_idle;
    wr(OFS_LO_PER, 16'hFFFF);
    wr(OFS_HI_CTL, 16'h0000);
    wr(OFS_LO_CTL, 16'hA008);
    idle_mode <= 1'b1;
    rd(OFS_LO_CNT);
    prev = v;
    rd(OFS_LO_CNT);
    check(v, prev);
    wr(OFS_LO_CTL, 16'h8008);
    rd(OFS_LO_CNT);
    prev = v;
    rd(OFS_LO_CNT);
    check({31'h0, v != prev}, 32'h1);
    idle_mode <= 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_regs;
    t_fifo;
    t_wake;
    t_timer;
    t_idle;
    close_out;
  end
  initial begin
    #100000;
    num_errors++;
    close_out;
  end
endmodule
